//--- hdl/timer_core.sv
/*
  Counter core of an 8-bit timer/counter with one compare channel,
  its prescaler, tick selection and an AXI4-Lite register slave.
  Assumes crystal_in_pin is synchronous to aclk and at least two
  aclk periods wide per level; interrupt acks are one-cycle pulses.
*/
`timescale 1ns/1ps

// Function
// - Counter and compare value are eight bits
// - Every request readable in flag register
// - Each request has its own mask bit
// - Clock select zero stops counter, holds value
// - Tick from io clock or crystal input
// - Continuous compare sets compare flag
// - Compare register is double buffered in the PWM modes
// - Value zero means counter at bottom
// - Value all ones means counter at max
// - Top is max or compare, per mode
// - Tick clears, increments or decrements counter
// - CPU reads and writes counter anytime
// - CPU counter write beats counting
// - Waveform mode field picks count sequence
// - Overflow flag set per mode, requests interrupt
// - Normal mode wraps, overflow when reaching zero
// - Mode two clears counter on match
// - Match flags next tick; ack or one clears
// - Counter write blocks next tick's match
module timer_core
  import timer_core_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic overflow_ack,
  input wire logic compare_ack,
  output logic overflow_request,
  output logic compare_request,
  input wire logic crystal_in_pin,
  output logic crystal_out_pin
);

  //////////////////////////////////////////////////////////////////
  // State
  //////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic awready;                 // Write address slot free
    logic wready;                  // Write data slot free
    logic bvalid;                  // Write answer pending
    logic [1:0] bresp;             // Write answer code
    logic arready;                 // Read slot free
    logic rvalid;                  // Read answer pending
    logic [AXI_DATA_W-1:0] rdata;  // Read answer data
    logic [1:0] rresp;             // Read answer code
    logic aw_have;                 // Address held
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_have;                  // Data held
    logic [7:0] w_data;            // Low byte of write data
    logic w_lane0;                 // Low byte lane enabled
    logic [1:0] wave;              // Waveform mode field
    logic [2:0] cs;                // Clock select field
    logic async_sel;               // Crystal tick source
    logic [7:0] count;             // Counter value
    logic [7:0] cmp_buf;           // CPU side of compare
    logic [7:0] cmp_act;           // Value the comparator uses
    logic [1:0] mask;              // Request masks
    logic [1:0] flag;              // Sticky flags
    logic [1:0] req;               // Masked requests
    logic dir_down;                // Phase correct direction
    logic block;                   // Match blocked for a tick
    logic [PRESCALE_W-1:0] prescale;
    logic xtal_prev;               // Crystal level last cycle
    logic xtal_out;                // Oscillator drive
  } timer_state_t;

  timer_state_t s_r;
  timer_state_t s_nxt;

  // Decoded events shared by logic and checks
  logic wr_go;
  logic cnt_wr;
  logic tick;
  logic xtal_rise;
  logic src_pulse;
  logic at_bottom;
  logic at_max;
  logic at_top;
  logic cmp_eq;
  logic pwm_mode;
  logic match_evt;
  logic ovf_evt;
  logic [7:0] top_val;
  logic [7:0] step_val;
  logic step_dir;
  logic [1:0] clr_bits;
  logic [AXI_DATA_W-1:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  //////////////////////////////////////////////////////////////////
  // Next state
  //////////////////////////////////////////////////////////////////

  // One pass computes bus, tick, counter and flag updates
  always_comb
  begin
    s_nxt = s_r;
    rd_word = '0;
    rd_hit = 1'b1;
    wr_hit = 1'b1;
    clr_bits = 2'h0;

    // Crystal edges seen in the io clock; no second domain
    xtal_rise = crystal_in_pin & ~s_r.xtal_prev;
    s_nxt.xtal_prev = crystal_in_pin;
    s_nxt.xtal_out = s_r.async_sel & ~crystal_in_pin;
    // Source pulse: every cycle, or crystal rising edge
    src_pulse = s_r.async_sel ? xtal_rise : 1'b1;
    // Prescaler taps per clock select; stop code gives no tick
    if (s_r.cs == CS_STOP)
    begin
      s_nxt.prescale = '0;
      tick = 1'b0;
    end
    else
    begin
      tick = src_pulse &
        ((s_r.prescale & PRESCALE_MASK[s_r.cs]) == PRESCALE_MASK[s_r.cs]);
      if (src_pulse)
        s_nxt.prescale = s_r.prescale + PRESCALE_ONE;
    end

    // Limits of the count sequence
    at_bottom = (s_r.count == COUNT_BOTTOM);
    at_max = (s_r.count == COUNT_MAX);
    top_val = (s_r.wave == WAVE_CTC) ? s_r.cmp_act : COUNT_MAX;
    at_top = (s_r.count == top_val);
    cmp_eq = (s_r.count == s_r.cmp_act);
    pwm_mode = s_r.wave[0];

    // Step per mode: clear, up or down
    step_dir = s_r.dir_down;
    unique case (s_r.wave)
      WAVE_NORMAL: step_val = s_r.count + COUNT_STEP; // Wraps
      WAVE_FAST: step_val = s_r.count + COUNT_STEP;
      WAVE_CTC: step_val = at_top ? COUNT_BOTTOM : s_r.count + COUNT_STEP; // Clear at the compare top
      WAVE_PHASE:
      begin
        // Turn at max and at bottom
        if (s_r.dir_down)
        begin
          step_dir = ~at_bottom;
          step_val = at_bottom ? s_r.count + COUNT_STEP : s_r.count - COUNT_STEP;
        end
        else
        begin
          step_dir = at_max;
          step_val = at_max ? s_r.count - COUNT_STEP : s_r.count + COUNT_STEP;
        end
      end
    endcase

    // Write side: address and data taken in either order
    if (s_axi_awvalid && s_r.awready)
    begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready)
    begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    wr_go = s_r.aw_have & s_r.w_have & ~s_r.bvalid;
    cnt_wr = wr_go & s_r.w_lane0 & (s_r.aw_addr == OFS_COUNT);

    // Counter: CPU write first, then tick
    if (cnt_wr)
      s_nxt.count = s_r.w_data;
    else if (tick)
    begin
      s_nxt.count = step_val;
      s_nxt.dir_down = step_dir;
    end

    // Write blocks the match of the following tick
    if (cnt_wr)
      s_nxt.block = 1'b1;
    else if (tick)
      s_nxt.block = 1'b0;

    // Match seen at a tick sets the flag at that tick's edge
    match_evt = tick & cmp_eq & ~s_r.block & ~cnt_wr;

    // Overflow: at bottom in phase correct, else on the wrap
    if (s_r.wave == WAVE_PHASE)
      ovf_evt = tick & ~cnt_wr & s_r.dir_down & (s_r.count == COUNT_STEP);
    else
      ovf_evt = tick & ~cnt_wr & at_max;

    // Buffered compare loads at max in the PWM modes
    if (tick && at_max && pwm_mode)
      s_nxt.cmp_act = s_r.cmp_buf;

    // Register writes
    if (wr_go)
    begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      if (s_r.w_lane0)
      begin
        unique case (s_r.aw_addr)
          OFS_CTRL_A:
          begin
            s_nxt.wave = s_r.w_data[CTRL_WAVE_LSB +: 2];
            s_nxt.cs = s_r.w_data[CTRL_CS_LSB +: 3];
          end
          OFS_COUNT: ;
          OFS_COMPARE:
          begin
            // Without buffering the write lands at once
            s_nxt.cmp_buf = s_r.w_data;
            if (!pwm_mode)
              s_nxt.cmp_act = s_r.w_data;
          end
          OFS_MASK: s_nxt.mask = s_r.w_data[1:0];
          OFS_FLAG: clr_bits = s_r.w_data[1:0];   // Write one clears
          OFS_ASYNC: s_nxt.async_sel = s_r.w_data[ASYNC_SEL_BIT];
          default: wr_hit = 1'b0;
        endcase
      end
      else
      begin
        wr_hit = (s_r.aw_addr == OFS_CTRL_A) || (s_r.aw_addr == OFS_COUNT) ||
          (s_r.aw_addr == OFS_COMPARE) || (s_r.aw_addr == OFS_MASK) ||
          (s_r.aw_addr == OFS_FLAG) || (s_r.aw_addr == OFS_ASYNC);
      end
      s_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    s_nxt.awready = ~s_nxt.aw_have;
    s_nxt.wready = ~s_nxt.w_have;

    // Sticky flags: a set in the clearing cycle wins
    clr_bits[FLAG_OVF_BIT] = clr_bits[FLAG_OVF_BIT] | overflow_ack;
    clr_bits[FLAG_CMP_BIT] = clr_bits[FLAG_CMP_BIT] | compare_ack;
    s_nxt.flag = s_r.flag & ~clr_bits;
    s_nxt.flag[FLAG_OVF_BIT] = s_nxt.flag[FLAG_OVF_BIT] | ovf_evt;
    s_nxt.flag[FLAG_CMP_BIT] = s_nxt.flag[FLAG_CMP_BIT] | match_evt;

    // Each request gated by its own mask
    s_nxt.req = s_r.flag & s_r.mask;

    // Read mux; the compare read shows the CPU side copy in the PWM modes, else the active copy
    unique case (s_axi_araddr)
      OFS_CTRL_A:
      begin
        rd_word[CTRL_WAVE_LSB +: 2] = s_r.wave;
        rd_word[CTRL_CS_LSB +: 3] = s_r.cs;
      end
      OFS_COUNT: rd_word[7:0] = s_r.count;
      OFS_COMPARE: rd_word[7:0] = pwm_mode ? s_r.cmp_buf : s_r.cmp_act;
      OFS_MASK: rd_word[1:0] = s_r.mask;
      OFS_FLAG: rd_word[1:0] = s_r.flag;
      OFS_ASYNC: rd_word[ASYNC_SEL_BIT] = s_r.async_sel;
      default: rd_hit = 1'b0;
    endcase
    if (s_axi_arvalid && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_word;
      s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    // One read at a time keeps the slave simple
    s_nxt.arready = ~s_nxt.rvalid;
  end

  // Register the whole state; reset clears everything
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////
  // Outputs, all straight from state
  //////////////////////////////////////////////////////////////////

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign overflow_request = s_r.req[FLAG_OVF_BIT];
  assign compare_request = s_r.req[FLAG_CMP_BIT];
  assign crystal_out_pin = s_r.xtal_out;

  //////////////////////////////////////////////////////////////////
  // Checks
  //////////////////////////////////////////////////////////////////

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stop_holds: assert property (
    (s_r.cs == CS_STOP) && !cnt_wr |=> (s_r.count == $past(s_r.count)))
    else $error("counter moved while stopped");
  a_async_no_edge: assert property (
    s_r.async_sel && !xtal_rise && !cnt_wr |=> $stable(s_r.count))
    else $error("counter moved without crystal edge");
  a_write_wins: assert property (
    cnt_wr |=> (s_r.count == $past(s_r.w_data)))
    else $error("counter write lost");
  a_normal_wrap: assert property (
    tick && !cnt_wr && (s_r.wave == WAVE_NORMAL) && at_max
    |=> (s_r.count == COUNT_BOTTOM) && s_r.flag[FLAG_OVF_BIT])
    else $error("normal wrap or overflow wrong");
  a_ctc_clear: assert property (
    tick && !cnt_wr && (s_r.wave == WAVE_CTC) && cmp_eq |=> (s_r.count == COUNT_BOTTOM))
    else $error("match did not clear counter");
  a_match_flag: assert property (
    tick && cmp_eq && !s_r.block && !cnt_wr |=> s_r.flag[FLAG_CMP_BIT] ##1 1'b1)
    else $error("match flag not set");
  a_block_match: assert property (
    cnt_wr ##1 (tick && !s_r.flag[FLAG_CMP_BIT] && !cnt_wr) |=> !s_r.flag[FLAG_CMP_BIT])
    else $error("blocked match set flag");
  a_dbuf_hold: assert property (
    pwm_mode && !(tick && at_max) |=> $stable(s_r.cmp_act))
    else $error("active compare changed off max");
  a_mask_gate: assert property (
    ##1 (overflow_request == ($past(s_r.flag[FLAG_OVF_BIT]) && $past(s_r.mask[FLAG_OVF_BIT])))
    && (compare_request == ($past(s_r.flag[FLAG_CMP_BIT]) && $past(s_r.mask[FLAG_CMP_BIT]))))
    else $error("request not gated by mask");
  a_phase_turn: assert property (
    tick && !cnt_wr && (s_r.wave == WAVE_PHASE) && at_max && !s_r.dir_down
    |=> s_r.dir_down && (s_r.count == $past(s_r.count) - COUNT_STEP))
    else $error("phase correct did not turn at max");
endmodule : timer_core

//--- inc/timer_core_pkg.sv
/*
  Constants for the 8-bit timer/counter core: register offsets,
  field positions, mode codes, limits and prescaler taps.
  Assumes a 32-bit AXI4-Lite bus with byte addresses.
*/
package timer_core_pkg;
  // Bus geometry and answers
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_FLAG = 8'h10;
  localparam logic [7:0] OFS_ASYNC = 8'h14;
  // Field positions
  localparam int CTRL_WAVE_LSB = 0;
  localparam int CTRL_CS_LSB = 2;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int ASYNC_SEL_BIT = 0;
  // Waveform mode codes
  localparam logic [1:0] WAVE_NORMAL = 2'h0;
  localparam logic [1:0] WAVE_PHASE = 2'h1;
  localparam logic [1:0] WAVE_CTC = 2'h2;
  localparam logic [1:0] WAVE_FAST = 2'h3;
  // Clock select code that stops the timer
  localparam logic [2:0] CS_STOP = 3'h0;
  // Counter limits
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  // Prescaler width and the tap mask per clock select code
  localparam int PRESCALE_W = 10;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 10'h001;
  localparam logic [PRESCALE_W-1:0] PRESCALE_MASK [8] = '{
    10'h000, 10'h000, 10'h007, 10'h01F,
    10'h03F, 10'h07F, 10'h0FF, 10'h3FF
  };
endpackage : timer_core_pkg

//--- verification/crystal_model.sv
/*
  Behavioural model of the watch crystal on the timer's crystal input.
  Assumes the bench raises run only while it wants timer ticks from it.
*/
`timescale 1ns/1ps

module crystal_model #(
  parameter int HALF_NS = 180 // 3.6 bus clocks; its edges never land on a rising aclk edge
) (
  input wire logic run,
  output logic crystal_in_pin
);
  // Oscillates only while run is high; rests low so no stray edges appear
  initial crystal_in_pin = 1'b0;
  always
  begin
    #(HALF_NS);
    crystal_in_pin = run ? ~crystal_in_pin : 1'b0;
  end
endmodule : crystal_model

//--- verification/timer_core_tb.sv
/*
  Self-checking bench for timer_core: an AXI4-Lite master, a crystal model
  and one task per scenario. Assumes a 50 ns clock and a synchronous reset.
*/
`timescale 1ns/1ps

module timer_core_tb;
  import timer_core_pkg::*;
  logic aclk, aresetn; // Clock and active-low reset
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd; // rd holds the last read word
  logic [1:0] bresp, rresp, rs; // rs holds the last response code
  logic ovf_ack, cmp_ack, ovf_req, cmp_req, xtal, xout, xrun;
  int n_fail, total_checks, edges;

  timer_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .overflow_ack(ovf_ack),
    .compare_ack(cmp_ack), .overflow_request(ovf_req), .compare_request(cmp_req),
    .crystal_in_pin(xtal), .crystal_out_pin(xout));
  crystal_model XM (.run(xrun), .crystal_in_pin(xtal));

  // Free-running bus clock
  always #25 aclk = ~aclk;
  // Count what the crystal really delivered
  always @(posedge xtal) edges++;

  ////////////////////////////////////////////////////////////////////////////
  // Compare and tally; a mismatch is reported at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Write one word; each channel is released when taken, only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  // Read one word into rd and rs
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  // Read and compare in one call
  task automatic chkr(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rd, exp);
  endtask : chkr

  // Start with a control value, run n cycles, stop keeping the mode
  task automatic run(input logic [7:0] c, input int n);
    wr(OFS_CTRL_A, c);
    repeat (n) @(posedge aclk);
    wr(OFS_CTRL_A, c & 8'h03);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped address
  task automatic t_reset;
    logic [7:0] ofs [6];
    ofs = '{OFS_CTRL_A, OFS_COUNT, OFS_COMPARE, OFS_MASK, OFS_FLAG, OFS_ASYNC};
    foreach (ofs[i])
      chkr(ofs[i], 32'h00000000);
    wr(8'h18, 8'hFF);
    chk(rs, RESP_SLVERR);
    chkr(8'h18, 32'h00000000);
    chk(rs, RESP_SLVERR);
    $display("test reset_map done");
  endtask : t_reset

  // Stopped counter holds a written value
  task automatic t_stop;
    wr(OFS_COUNT, 8'h5A);
    repeat (20) @(posedge aclk);
    chkr(OFS_COUNT, 32'h0000005A);
    $display("test stopped done");
  endtask : t_stop

  // Clock select two ticks once per eight bus clocks
  task automatic t_prescale;
    wr(OFS_COUNT, 8'h00);
    run(8'h08, 80);
    rd_reg(OFS_COUNT);
    chk(rd >= 32'h09 && rd <= 32'h0B, 1'b1);
    $display("test prescale done");
  endtask : t_prescale

  // Write while counting wins over the increment
  task automatic t_prio;
    wr(OFS_COUNT, 8'h10);
    wr(OFS_CTRL_A, 8'h04);
    wr(OFS_COUNT, 8'h80);
    wr(OFS_CTRL_A, 8'h00);
    rd_reg(OFS_COUNT);
    chk(rd >= 32'h80 && rd < 32'h88, 1'b1);
    $display("test write_priority done");
  endtask : t_prio

  // Normal wrap sets overflow; mask, ack and write-one clear
  task automatic t_ovf;
    wr(OFS_COUNT, 8'hF0);
    wr(OFS_MASK, 8'h01);
    run(8'h04, 30);
    chk(ovf_req, 1'b1);
    chk(cmp_req, 1'b0);
    rd_reg(OFS_FLAG);
    chk(rd, 32'h00000003);
    @(posedge aclk);
    ovf_ack <= 1'b1;
    @(posedge aclk);
    ovf_ack <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(ovf_req, 1'b0);
    wr(OFS_FLAG, 8'h02);
    chkr(OFS_FLAG, 32'h00000000);
    $display("test overflow done");
  endtask : t_ovf

  // Clear on compare keeps the count at or below the compare value
  task automatic t_ctc;
    wr(OFS_COUNT, 8'h00);
    wr(OFS_COMPARE, 8'h10);
    run(8'h06, 60);
    rd_reg(OFS_COUNT);
    chk(rd <= 32'h10, 1'b1);
    chkr(OFS_FLAG, 32'h00000002);
    wr(OFS_MASK, 8'h02);
    @(posedge aclk);
    chk(cmp_req, 1'b1);
    @(posedge aclk);
    cmp_ack <= 1'b1;
    @(posedge aclk);
    cmp_ack <= 1'b0;
    chkr(OFS_FLAG, 32'h00000000);
    chk(cmp_req, 1'b0);
    $display("test clear_on_compare done");
  endtask : t_ctc

  // A count write blocks only the next tick's match
  task automatic t_block;
    wr(OFS_COMPARE, 8'h22);
    wr(OFS_COUNT, 8'h22);
    run(8'h04, 10);
    chkr(OFS_FLAG, 32'h00000000);
    wr(OFS_COUNT, 8'h21);
    run(8'h04, 10);
    chkr(OFS_FLAG, 32'h00000002);
    wr(OFS_FLAG, 8'h02);
    $display("test match_block done");
  endtask : t_block

  // Crystal ticks: the count equals the rising edges delivered
  task automatic t_async;
    wr(OFS_COUNT, 8'h00);
    wr(OFS_ASYNC, 8'h01);
    wr(OFS_CTRL_A, 8'h04);
    edges = 0;
    xrun <= 1'b1;
    repeat (100) @(posedge aclk);
    xrun <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(xout, 1'b1);
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_ASYNC, 8'h00);
    chkr(OFS_COUNT, edges & 32'hFF);
    chk(edges >= 8, 1'b1);
    chk(xout, 1'b0);
    $display("test crystal_source done");
  endtask : t_async

  // Fast PWM counts up to MAX and wraps with overflow
  task automatic t_fast;
    wr(OFS_COMPARE, 8'h30);
    wr(OFS_COUNT, 8'hF8);
    run(8'h07, 20);
    rd_reg(OFS_COUNT);
    chk(rd < 32'h20, 1'b1);
    chkr(OFS_FLAG, 32'h00000001);
    wr(OFS_FLAG, 8'h01);
    $display("test fast_pwm done");
  endtask : t_fast

  // Phase correct turns at MAX and counts down; last, as direction persists
  task automatic t_phase;
    wr(OFS_COUNT, 8'hFE);
    run(8'h05, 20);
    rd_reg(OFS_COUNT);
    chk(rd < 32'hFE && rd > 32'hD0, 1'b1);
    wr(OFS_COMPARE, 8'h40);
    chkr(OFS_COMPARE, 32'h00000040);
    $display("test phase_correct done");
  endtask : t_phase

  ////////////////////////////////////////////////////////////////////////////
  // Counts, then the verdict; the only place the run ends
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, ovf_ack, cmp_ack, xrun} = 8'h00;
    {awaddr, araddr, wdata} = 48'h000000000000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_stop();
    t_prescale();
    t_prio();
    t_ovf();
    t_ctc();
    t_block();
    t_async();
    t_fast();
    t_phase();
    print_verdict();
  end

  // Watchdog: the tests need under 1500 cycles, so 4000 means a hang
  initial
  begin
    #200us;
    n_fail++;
    print_verdict();
  end
endmodule : timer_core_tb
